// ===== station_alias_loader.sv
`timescale 1ns/1ps

module station_alias_loader (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // slave controller register port
  input  wire logic [15:0] reg_addr_i,
  input  wire logic        reg_rd_i,
  input  wire logic        reg_wr_i,
  input  wire logic [15:0] reg_wdata_i,
  output logic             reg_ack_o,
  output logic [15:0]      reg_rdata_o,
  // backup non-volatile store read port
  output logic             nv_req_o,
  output logic [15:0]      nv_index_o,
  input  wire logic        nv_ack_i,
  input  wire logic [15:0] nv_data_i,
  // interface store read port
  output logic             sii_req_o,
  output logic [15:0]      sii_addr_o,
  input  wire logic        sii_ack_i,
  input  wire logic [15:0] sii_data_i,
  // dictionary object writes from the application side
  input  wire logic        obj_wr_i,
  input  wire logic [15:0] obj_index_i,
  input  wire logic [15:0] obj_wdata_i,
  output logic             obj_err_o,
  output logic [15:0]      obj_rdata_o,
  // front-panel rotary switch pins
  input  wire logic [7:0]  rotary_i,
  // communication alarm status
  input  wire logic        comm_alarm_i,
  input  wire logic [15:0] comm_alarm_code_i,
  // load status
  output logic             load_done_o,
  output logic             active_sel_o
);
  import alias_loader_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state
  load_state_t     ld_q, ld_d;
  id_state_t       id_q, id_d;
  logic [7:0]      rot_meta_q;
  logic [7:0]      rot_q;
  logic [15:0]     sel_store_q;    // stored setting, may change after power-on
  logic [15:0]     upper_store_q;
  logic [15:0]     sel_active_q;   // values latched at power-on
  logic [7:0]      upper_active_q;
  logic [15:0]     node_alias_q;
  logic [15:0]     al_ctrl_q;
  logic            id_loaded_q;
  logic [15:0]     al_code_q;
  logic [15:0]     reg_rdata_q;
  logic            obj_err_q;
  logic [15:0]     obj_rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // decode and selection
  wire logic        hit_alias  = (reg_addr_i == OFS_NODE_ALIAS);
  wire logic        hit_ctrl   = (reg_addr_i == OFS_APP_LAYER_CTRL);
  wire logic        hit_state  = (reg_addr_i == OFS_APP_LAYER_STATE);
  wire logic        hit_code   = (reg_addr_i == OFS_APP_LAYER_CODE);
  wire logic        ctrl_wr    = ce_i & reg_wr_i & hit_ctrl;
  wire logic        id_request = al_ctrl_q[ID_REQUEST_BIT];
  // switch alias built from the latched upper byte and live switch
  wire logic [15:0] switch_alias = {upper_active_q, rot_q};
  wire logic [15:0] id_answer    = comm_alarm_i ? comm_alarm_code_i
                                                : switch_alias;
  wire logic        nv_got     = nv_ack_i & ce_i;
  wire logic        sii_got    = sii_ack_i & ce_i;
  wire logic        wr_sel     = ce_i & obj_wr_i & (obj_index_i == IDX_ALIAS_SOURCE_SEL);
  wire logic        wr_upper   = ce_i & obj_wr_i & (obj_index_i == IDX_ALIAS_UPPER_BYTE);
  wire logic        sel_ok     = (obj_wdata_i < SEL_MAKER_ONLY);
  wire logic        upper_ok   = (obj_wdata_i <= UPPER_BYTE_MAX);
  wire logic        loading    = (ld_q != LD_DONE);

  // read data mux, status assembled from its bit fields
  logic [15:0] state_word;
  logic [15:0] rd_mux;
  always_comb begin
    state_word                = 16'h0000;
    state_word[ID_LOADED_BIT] = id_loaded_q;
    if (hit_alias) begin
      rd_mux = node_alias_q;
    end else if (hit_ctrl) begin
      rd_mux = al_ctrl_q;
    end else if (hit_state) begin
      rd_mux = state_word;
    end else if (hit_code) begin
      rd_mux = al_code_q;
    end else begin
      rd_mux = 16'h0000;
    end
  end

  // reads wait until the power-on load has finished
  assign reg_ack_o   = (reg_rd_i & ~loading) | reg_wr_i;
  assign reg_rdata_o = reg_rdata_q;
  assign load_done_o = ~loading;
  assign active_sel_o = sel_active_q[0];
  assign obj_err_o   = obj_err_q;
  assign obj_rdata_o = obj_rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // power-on fetch requests
  always_comb begin
    nv_req_o   = 1'b0;
    nv_index_o = IDX_ALIAS_SOURCE_SEL;
    sii_req_o  = 1'b0;
    sii_addr_o = SII_ALIAS_WORD;
    case (ld_q)
      LD_FETCH_SEL: begin
        nv_req_o   = 1'b1;
        nv_index_o = IDX_ALIAS_SOURCE_SEL;
      end
      LD_FETCH_UPPER: begin
        nv_req_o   = 1'b1;
        nv_index_o = IDX_ALIAS_UPPER_BYTE;
      end
      LD_FETCH_SII: begin
        sii_req_o  = 1'b1;
      end
      default: begin
        nv_req_o   = 1'b0;
      end
    endcase
  end

  // power-on fetch sequence
  always_comb begin
    ld_d = ld_q;
    case (ld_q)
      LD_FETCH_SEL: begin
        if (nv_got) begin
          ld_d = LD_FETCH_UPPER;
        end
      end
      LD_FETCH_UPPER: begin
        if (nv_got) begin
          ld_d = LD_DECIDE;
        end
      end
      LD_DECIDE: begin
        if (!ce_i) begin
          ld_d = LD_DECIDE;
        end else if (sel_active_q == SEL_FROM_SII) begin
          ld_d = LD_FETCH_SII;
        end else begin
          ld_d = LD_DONE;
        end
      end
      LD_FETCH_SII: begin
        if (sii_got) begin
          ld_d = LD_DONE;
        end
      end
      default: begin
        ld_d = LD_DONE;
      end
    endcase
  end

  // explicit id handshake sequence
  always_comb begin
    id_d = id_q;
    case (id_q)
      ID_IDLE: begin
        if (id_request && !loading) begin
          id_d = ID_SHOWN;
        end
      end
      ID_SHOWN: begin
        if (!id_request) begin
          id_d = ID_RELEASE;
        end
      end
      ID_RELEASE: begin
        id_d = ID_IDLE;
      end
      default: begin
        id_d = ID_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // rotary switch synchroniser
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rot_meta_q <= 8'h00;
      rot_q      <= 8'h00;
    end else if (ce_i) begin
      rot_meta_q <= rotary_i;
      rot_q      <= rot_meta_q;
    end
  end

  // state registers
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ld_q <= LD_FETCH_SEL;
      id_q <= ID_IDLE;
    end else if (ce_i) begin
      ld_q <= ld_d;
      id_q <= id_d;
    end
  end

  // stored settings, held but not applied until the next power-on
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sel_store_q   <= SEL_RESET;
      upper_store_q <= UPPER_BYTE_RESET;
      obj_err_q     <= 1'b0;
      obj_rdata_q   <= 16'h0000;
    end else if (ld_q == LD_FETCH_SEL && nv_got) begin
      sel_store_q   <= nv_data_i;
    end else if (ld_q == LD_FETCH_UPPER && nv_got) begin
      upper_store_q <= nv_data_i;
    end else if (ce_i) begin
      obj_err_q   <= (wr_sel & ~sel_ok) | (wr_upper & ~upper_ok);
      obj_rdata_q <= (obj_index_i == IDX_ALIAS_SOURCE_SEL) ? sel_store_q : upper_store_q;
      if (wr_sel && sel_ok) begin
        sel_store_q <= obj_wdata_i;
      end
      if (wr_upper && upper_ok) begin
        upper_store_q <= obj_wdata_i;
      end
    end
  end

  // active settings latched only during the power-on fetch
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sel_active_q   <= SEL_RESET;
      upper_active_q <= 8'h00;
    end else if (ld_q == LD_FETCH_SEL && nv_got) begin
      sel_active_q   <= nv_data_i;
    end else if (ld_q == LD_FETCH_UPPER && nv_got) begin
      upper_active_q <= nv_data_i[ALIAS_HALF_W-1:0];
    end
  end

  // configured alias register fill
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      node_alias_q <= 16'h0000;
    end else if (ld_q == LD_FETCH_SII && sii_got) begin
      node_alias_q <= sii_data_i;
    end else if (ce_i && ld_q == LD_DECIDE && sel_active_q == SEL_FROM_SWITCH) begin
      node_alias_q <= switch_alias;
    end
  end

  // control register written by the master
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      al_ctrl_q <= 16'h0000;
    end else if (ctrl_wr) begin
      al_ctrl_q <= reg_wdata_i;
    end
  end

  // status code and loaded flag of the id handshake
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      al_code_q   <= 16'h0000;
      id_loaded_q <= 1'b0;
    end else if (ce_i) begin
      case (id_q)
        ID_IDLE: begin
          if (id_request && !loading) begin
            al_code_q <= id_answer;
          end
        end
        ID_SHOWN: begin
          id_loaded_q <= id_request;
          if (id_request) begin
            al_code_q <= id_answer;
          end
        end
        ID_RELEASE: begin
          al_code_q <= 16'h0000;
        end
        default: begin
          id_loaded_q <= 1'b0;
        end
      endcase
    end
  end

  // registered read data
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_q <= 16'h0000;
    end else if (ce_i && reg_rd_i && !loading) begin
      reg_rdata_q <= rd_mux;
    end
  end

endmodule : station_alias_loader

// ===== alias_loader_pkg.sv
package alias_loader_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // slave controller register offsets
  localparam logic [15:0] OFS_NODE_ALIAS       = 16'h0012;
  localparam logic [15:0] OFS_APP_LAYER_CTRL   = 16'h0120;
  localparam logic [15:0] OFS_APP_LAYER_STATE  = 16'h0130;
  localparam logic [15:0] OFS_APP_LAYER_CODE   = 16'h0134;

  // handshake bit positions in control and status
  localparam int unsigned ID_REQUEST_BIT = 5;
  localparam int unsigned ID_LOADED_BIT  = 5;

  ////////////////////////////////////////////////////////////////////////////
  // dictionary indices of the stored settings
  localparam logic [15:0] IDX_ALIAS_UPPER_BYTE  = 16'h3740;
  localparam logic [15:0] IDX_ALIAS_SOURCE_SEL  = 16'h3741;

  // word address of the alias in the interface store
  localparam logic [15:0] SII_ALIAS_WORD        = 16'h0004;

  ////////////////////////////////////////////////////////////////////////////
  // source selection encodings and limits
  localparam logic [15:0] SEL_FROM_SWITCH       = 16'h0000;
  localparam logic [15:0] SEL_FROM_SII          = 16'h0001;
  localparam logic [15:0] SEL_MAKER_ONLY        = 16'h0002;
  localparam logic [15:0] SEL_RESET             = 16'h0001;
  localparam logic [15:0] UPPER_BYTE_MAX        = 16'h00FF;
  localparam logic [15:0] UPPER_BYTE_RESET      = 16'h0000;

  // field split of the combined alias
  localparam int unsigned ALIAS_HALF_W          = 8;

  // power-on fetch sequence
  typedef enum logic [2:0] {
    LD_FETCH_SEL,
    LD_FETCH_UPPER,
    LD_DECIDE,
    LD_FETCH_SII,
    LD_DONE
  } load_state_t;

  // explicit id handshake
  typedef enum logic [1:0] {
    ID_IDLE,
    ID_SHOWN,
    ID_RELEASE
  } id_state_t;

endpackage : alias_loader_pkg

// ===== alias_monitor.sv
`timescale 1ns/1ps
module alias_monitor
  import alias_loader_pkg::*;
(
  input wire logic        ref_clk_i,
  input wire logic        rst_i,
  input wire logic        reg_rd_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_ack_o,
  input wire logic        nv_req_o,
  input wire logic [15:0] nv_index_o,
  input wire logic        nv_ack_i,
  input wire logic        sii_req_o,
  input wire logic [15:0] sii_addr_o,
  input wire logic        sii_ack_i,
  input wire logic        obj_wr_i,
  input wire logic [15:0] obj_index_i,
  input wire logic [15:0] obj_wdata_i,
  input wire logic        obj_err_o,
  input wire logic [15:0] obj_rdata_o,
  input wire logic        load_done_o,
  input wire logic        active_sel_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // steps of the power-on fetch
  sequence sel_taken;
    nv_req_o && nv_ack_i && nv_index_o == IDX_ALIAS_SOURCE_SEL;
  endsequence
  sequence upper_taken;
    nv_req_o && nv_ack_i && nv_index_o == IDX_ALIAS_UPPER_BYTE;
  endsequence
  ////////////////////////////////////////////////////////////
  // load order, source choice, completion, held reads and refused settings
  AST_NV_ORDER: assert property (sel_taken |=> nv_index_o == IDX_ALIAS_UPPER_BYTE)
    else $error("upper byte not fetched after selection");
  AST_DECIDE: assert property (upper_taken |-> ##2 sii_req_o == active_sel_o)
    else $error("source fetch does not match selection");
  AST_SWITCH_DONE: assert property (upper_taken ##2 !sii_req_o |-> load_done_o)
    else $error("switch alias load not done");
  AST_SII_DONE: assert property (sii_req_o && sii_ack_i |=> load_done_o)
    else $error("store word load not done");
  AST_SII_WORD: assert property (sii_req_o |-> sii_addr_o == SII_ALIAS_WORD)
    else $error("wrong store word");
  AST_RD_HELD: assert property (reg_rd_i && !reg_wr_i && !load_done_o |-> !reg_ack_o)
    else $error("read answered during load");
  AST_QUIET: assert property (load_done_o |=> load_done_o && !nv_req_o && !sii_req_o)
    else $error("fetch after load done");
  AST_SEL_ERR: assert property (obj_wr_i && obj_index_i == IDX_ALIAS_SOURCE_SEL
    && obj_wdata_i >= SEL_MAKER_ONLY |=> obj_err_o)
    else $error("maker selection accepted");
  AST_UPPER_ERR: assert property (obj_wr_i && obj_index_i == IDX_ALIAS_UPPER_BYTE
    && obj_wdata_i > UPPER_BYTE_MAX |=> obj_err_o)
    else $error("upper byte above range accepted");
  // an accepted selection write is kept in the stored copy
  AST_SEL_KEPT: assert property (obj_wr_i && obj_index_i == IDX_ALIAS_SOURCE_SEL
    && obj_wdata_i < SEL_MAKER_ONLY && load_done_o
    ##1 obj_index_i == IDX_ALIAS_SOURCE_SEL |=> obj_rdata_o == $past(obj_wdata_i, 2))
    else $error("stored selection not kept");
endmodule : alias_monitor

bind station_alias_loader alias_monitor alias_monitor_inst (.*);

// ===== store_model.sv
`timescale 1ns/1ps
module store_model
  import alias_loader_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic        nv_req_i,
  input  wire logic [15:0] nv_index_i,
  input  wire logic        sii_req_i,
  input  wire logic [15:0] sel_i,
  input  wire logic [15:0] upper_i,
  input  wire logic [15:0] word_i,
  input  wire logic [2:0]  delay_i,
  output logic             nv_ack_o,
  output logic [15:0]      nv_data_o,
  output logic             sii_ack_o,
  output logic [15:0]      sii_data_o
);
  logic [2:0] wait_q;
  wire        busy = (nv_req_i && !nv_ack_o) || (sii_req_i && !sii_ack_o);
  wire [15:0] nv_val = (nv_index_i == IDX_ALIAS_SOURCE_SEL) ? sel_i : upper_i;
  // answer after delay_i cycles, inverted data while not answering
  assign nv_ack_o   = nv_req_i && wait_q >= delay_i;
  assign sii_ack_o  = sii_req_i && wait_q >= delay_i;
  assign nv_data_o  = nv_ack_o ? nv_val : ~nv_val;
  assign sii_data_o = sii_ack_o ? word_i : ~word_i;
  // wait counter restarts at each acknowledge
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wait_q <= 3'h0;
    end else begin
      wait_q <= busy ? wait_q + 3'h1 : 3'h0;
    end
  end
endmodule : store_model

// ===== testbench.sv
`timescale 1ns/1ps
module testbench;
  import alias_loader_pkg::*;
  logic        ref_clk_i = 1'h0, rst_i = 1'h1, ce_i = 1'h1, chk_q = 1'h0;
  logic        reg_rd_i = 1'h0, reg_wr_i = 1'h0, obj_wr_i = 1'h0, comm_alarm_i = 1'h0;
  logic [15:0] reg_addr_i = '0, reg_wdata_i = '0, obj_index_i = '0, obj_wdata_i = '0;
  logic [15:0] comm_alarm_code_i = '0, sel_v = '0, upper_v = '0, sii_v = '0, exp_v;
  logic [7:0]  rotary_i = '0, up, rot;
  logic [2:0]  dly = '0;
  logic        reg_ack_o, nv_req_o, nv_ack_i, sii_req_o, sii_ack_i, obj_err_o;
  logic        load_done_o, active_sel_o;
  logic [15:0] reg_rdata_o, nv_index_o, nv_data_i, sii_addr_o, sii_data_i, obj_rdata_o;
  logic [31:0] note_v;
  logic [31:0] exp_q[$];
  int          mismatches = 0, samples_checked = 0;
  localparam logic [15:0] OFS_NODE_ADDR = 16'h0010;

  station_alias_loader station_alias_loader_inst (.*);
  store_model store_model_inst (.ref_clk_i, .rst_i, .nv_req_i(nv_req_o),
    .nv_index_i(nv_index_o), .sii_req_i(sii_req_o), .sel_i(sel_v), .upper_i(upper_v),
    .word_i(sii_v), .delay_i(dly), .nv_ack_o(nv_ack_i), .nv_data_o(nv_data_i),
    .sii_ack_o(sii_ack_i), .sii_data_o(sii_data_i));

  always #20 ref_clk_i = ~ref_clk_i;

  // compare each answered read with the oldest note
  always @(posedge ref_clk_i) begin
    if (chk_q) begin
      note_v = exp_q.pop_front();
      samples_checked++;
      if ((reg_rdata_o & note_v[31:16]) !== note_v[15:0]) begin
        mismatches++;
        $display("FAIL %0t read %h expected %h", $time, reg_rdata_o, note_v[15:0]);
      end
    end
    chk_q <= reg_rd_i && reg_ack_o;
  end

  ////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test

  // power-on with fresh store contents
  task automatic por(input logic [15:0] s, input logic [2:0] d);
    @(posedge ref_clk_i);
    rst_i    <= 1'h1;
    sel_v    <= s;
    upper_v  <= {8'h00, up};
    rotary_i <= rot;
    sii_v    <= 16'($urandom);
    dly      <= d;
    repeat (2) @(posedge ref_clk_i);
    rst_i    <= 1'h0;
  endtask : por

  // one register or object write
  task automatic put(input logic o, input logic [15:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    reg_wr_i    <= !o;
    obj_wr_i    <= o;
    reg_addr_i  <= a;
    obj_index_i <= a;
    reg_wdata_i <= d;
    obj_wdata_i <= d;
    @(posedge ref_clk_i);
    reg_wr_i    <= 1'h0;
    obj_wr_i    <= 1'h0;
  endtask : put

  // read held until acknowledged, expectation noted
  task automatic rd(input logic [15:0] a, input logic [15:0] e, input logic [15:0] m);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    reg_rd_i   <= 1'h1;
    reg_addr_i <= a;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (reg_ack_o !== 1'h1 && n < 100);
    reg_rd_i <= 1'h0;
    if (reg_ack_o === 1'h1) begin
      exp_q.push_back({m, e & m});
    end else begin
      mismatches++;
      $display("FAIL %0t read not answered", $time);
      stop_test();
    end
  endtask : rd

  initial begin
    void'($urandom(32'h08A2));
    // maker value, zero switch, switch source, store word source
    for (int i = 0; i < 4; i++) begin
      up  = (i == 1) ? 8'h00 : 8'($urandom_range(255));
      rot = (i == 1) ? 8'h00 : 8'($urandom_range(255));
      por(i == 3 ? SEL_FROM_SII : i == 0 ? SEL_MAKER_ONLY : SEL_FROM_SWITCH, 3'(i));
      exp_v = (i == 3) ? sii_v : (i == 2) ? {up, rot} : 16'h0000;
      rd(OFS_NODE_ALIAS, exp_v, 16'hFFFF);
    end
    $display("power-on load test done");
    // id handshake with a new switch value and an alarm in between
    rot = 8'($urandom);
    rotary_i <= rot;
    repeat (3) @(posedge ref_clk_i);
    put(1'h0, OFS_APP_LAYER_CTRL, 16'h0020);
    // frozen clock enable holds the handshake in idle
    ce_i <= 1'h0;
    repeat (4) @(posedge ref_clk_i);
    ce_i <= 1'h1;
    rd(OFS_APP_LAYER_STATE, 16'h0000, 16'h0020);
    repeat (3) @(posedge ref_clk_i);
    rd(OFS_APP_LAYER_STATE, 16'h0020, 16'h0020);
    rd(OFS_APP_LAYER_CODE, {up, rot}, 16'hFFFF);
    comm_alarm_code_i <= 16'($urandom);
    comm_alarm_i      <= 1'h1;
    repeat (2) @(posedge ref_clk_i);
    rd(OFS_APP_LAYER_CODE, comm_alarm_code_i, 16'hFFFF);
    comm_alarm_i <= 1'h0;
    repeat (2) @(posedge ref_clk_i);
    rd(OFS_APP_LAYER_CODE, {up, rot}, 16'hFFFF);
    put(1'h0, OFS_APP_LAYER_CTRL, 16'h0000);
    repeat (4) @(posedge ref_clk_i);
    rd(OFS_APP_LAYER_STATE, 16'h0000, 16'h0020);
    rd(OFS_APP_LAYER_CODE, 16'h0000, 16'hFFFF);
    $display("id handshake test done");
    // refused and late settings, unmapped read
    put(1'h1, IDX_ALIAS_SOURCE_SEL, SEL_MAKER_ONLY);
    put(1'h1, IDX_ALIAS_UPPER_BYTE, 16'h0100);
    put(1'h1, IDX_ALIAS_SOURCE_SEL, SEL_FROM_SWITCH);
    rd(OFS_NODE_ALIAS, sii_v, 16'hFFFF);
    put(1'h0, OFS_NODE_ADDR, sii_v);
    rd(16'h0200, 16'h0000, 16'hFFFF);
    $display("settings test done");
    repeat (2) @(posedge ref_clk_i);
    stop_test();
  end
endmodule : testbench
